/* File: hw/tws_filt.sv */
// Synchroniser and spike filter for clock and data lines
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
module tws_filt (
    input wire logic clk_link,
    input wire logic rst_link,
    input wire logic scl_i,
    input wire logic sda_i,
    tws_line_if.filt line
);
    logic [1:0] raw;
    logic [1:0] lvl;
    logic [1:0] next_lvl;
    logic [2:0] cnt [2];
    logic [2:0] next_cnt [2];
    logic [2:0] lim;

    tws_sync #(.W(2)) u_sync (
        .clk(clk_link),
        .d({scl_i, sda_i}),
        .q(raw)
    );

    // Shorter filter in high-speed mode keeps 3.4MHz pulses intact
    assign lim = line.hs ? 3'(`TWS_FILT_HS) : 3'(`TWS_FILT_FS); // RQ7

    // A level change must persist lim cycles before it is passed on
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_lvl[i] = lvl[i];
            next_cnt[i] = 3'h0;
            if (raw[i] != lvl[i]) begin // RQ25
                if (cnt[i] + 3'h1 >= lim) begin
                    next_lvl[i] = raw[i];
                end else begin
                    next_cnt[i] = cnt[i] + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            lvl <= `TWS_LINES_IDLE;
            cnt[0] <= 3'h0;
            cnt[1] <= 3'h0;
        end else begin
            lvl <= next_lvl;
            cnt <= next_cnt;
        end
    end

    assign line.scl = lvl[1];
    assign line.sda = lvl[0];
endmodule
`default_nettype wire

/* File: hw/tws_line_if.sv */
// Filtered bus lines and filter mode between filter and engine
`timescale 1ns/1ps
`default_nettype none
interface tws_line_if;
    logic scl;
    logic sda;
    logic hs;
    modport filt(output scl, output sda, input hs);
    modport eng(input scl, input sda, output hs);
endinterface
`default_nettype wire

/* File: hw/tws_map.svh */
// Constants of the two-wire slave with alarm output
// Summary of operation
// RQ1: Device is slave only; never drives clock, START or STOP.
// RQ2: Master opens each transfer with START: data falls while clock high.
// RQ3: Bytes take eight clocks; receiver acknowledges low on the ninth.
// RQ4: Data stable while clock high; changes then decode as START or STOP.
// RQ5: Master closes the transfer with STOP: data rises while clock high.
// RQ6: Every byte shifts most significant bit first.
// RQ7: Fast mode to 400kHz and high-speed mode to 3.4MHz supported.
// RQ8: Address byte is seven address bits then direction bit, high means read.
// RQ9: Two three-level strap pins select one of nine slave addresses.
// RQ10: First byte after write address loads the pointer register.
// RQ11: Reads use the last written pointer, kept until the next write.
// RQ12: Master changes pointer by address and pointer byte, then restart.
// RQ13: Wide registers are sent high byte first, then low byte.
// RQ14: Master decides the byte count; slave accepts any number.
// RQ15: Master ends a read with not-acknowledge; slave then stops driving.
// RQ16: High-speed master code gets no acknowledge; filters go high-speed.
// RQ17: High-speed mode survives repeated START and ends only on STOP; the code also ends it on a timeout.
// RQ18: With timeout enabled, line low 30ms in a frame resets the interface.
// RQ19: Alarm asserts after 1 to 4 consecutive out-of-limit conversions.
// RQ20: Alarm also asserts while the remote sensor is open.
// RQ21: Mask bit holds the alarm inactive regardless of conditions.
// RQ22: Alarm clears on address read only if cause and status are clear.
// RQ23: Consecutive code 000, 001, 011, 111 means one to four; one by default.
// RQ24: Alert response command gets address and cause; a win clears alarm.
// RQ25: Clock and data are synchronised and glitch filtered before decoding.
// RQ26: Bus and alarm outputs only pull low or release.
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

`define TWS_CLK_HZ 50000000
`define TWS_TOUT_MS 30
`define TWS_TOUT_CYC ((`TWS_CLK_HZ / 1000) * `TWS_TOUT_MS)
`define TWS_LINK_PER_NS 12
`define TWS_SPIKE_FS_NS 50
`define TWS_SPIKE_HS_NS 10
`define TWS_FILT_FS ((`TWS_SPIKE_FS_NS / `TWS_LINK_PER_NS) > 0 ? \
    (`TWS_SPIKE_FS_NS / `TWS_LINK_PER_NS) : 1)
`define TWS_FILT_HS ((`TWS_SPIKE_HS_NS / `TWS_LINK_PER_NS) > 0 ? \
    (`TWS_SPIKE_HS_NS / `TWS_LINK_PER_NS) : 1)
`define TWS_LINES_IDLE 2'h3
`define TWS_BIT_LAST 4'h8
`define TWS_HS_CODE 5'h01
`define TWS_ARA_CMD 8'h19
`define TWS_STRAP_GND 2'h0
`define TWS_STRAP_OPEN 2'h1
`define TWS_STRAP_VCC 2'h2
`define TWS_BASE_GND 7'h18
`define TWS_BASE_OPEN 7'h29
`define TWS_BASE_VCC 7'h4c
`define TWS_CONSEC_1 3'h0
`define TWS_CONSEC_2 3'h1
`define TWS_CONSEC_3 3'h3
`define TWS_CONSEC_4 3'h7

`endif

/* File: hw/tws_pkg.sv */
// Types shared by the two-wire slave modules
package tws_pkg;
    typedef enum logic [2:0] {
        TWS_IDLE, TWS_RX, TWS_ACK, TWS_TX, TWS_MACK
    } tws_state_t;
endpackage

/* File: hw/tws_sync.sv */
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage is read only by the second
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end
endmodule
`default_nettype wire

/* File: hw/tws_top.sv */
// Two-wire slave engine with alarm filter, mask and timeout
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
module tws_top #(
    parameter int TOUT_CYC = `TWS_TOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] addr_strap_first,
    input wire logic [1:0] addr_strap_second,
    output logic [7:0] reg_ptr,
    input wire logic [15:0] rd_data,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    output logic hs_mode,
    input wire logic conv_done,
    input wire logic conv_high,
    input wire logic conv_low,
    input wire logic remote_open,
    input wire logic status_clear,
    input wire logic alert_mask,
    input wire logic consec_count_bit_hi,
    input wire logic consec_count_bit_mid,
    input wire logic consec_count_bit_lo,
    input wire logic timeout_en,
    output logic alert_o,
    output logic alert_oe
);
    tws_line_if line ();
    logic rst_link;
    logic [6:0] lsync;
    logic [2:0] ssync;
    logic [6:0] my_addr;
    logic strap_taken;
    logic scl_q, sda_q, scl_rise, scl_fall, start_ev, stop_ev;
    logic tout_q, tout_ev, alert_act, alert_cause, tout_tog;
    tws_pkg::tws_state_t st, next_st;
    logic [7:0] sh, next_sh, next_ptr, next_wr_data, tx;
    logic [3:0] cnt, next_cnt;
    logic is_addr, next_is_addr, is_read, next_is_read;
    logic is_ara, next_is_ara, first_data, next_first_data;
    logic hs, next_hs, oe, next_oe, ack_ok, next_ack_ok;
    logic lsb, next_lsb, in_frame, next_in_frame;
    logic arb_lost, next_arb_lost, next_wr_strobe;
    logic tog_rd, next_tog_rd, tog_won, next_tog_won;

    // Open-drain pins: clock never driven, data only pulled low
    assign scl_o = 1'b0; // RQ1 RQ26
    assign scl_oe = 1'b0; // RQ1
    assign sda_o = 1'b0; // RQ26
    assign alert_o = 1'b0; // RQ26
    assign sda_oe = oe;
    assign hs_mode = hs;
    assign line.hs = hs;

    // Reset brought into the link domain
    tws_sync #(.W(1)) u_rst (.clk(clk_link), .d(rst), .q(rst_link));

    tws_filt u_filt (
        .clk_link(clk_link),
        .rst_link(rst_link),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line)
    );

    // Straps, alarm levels and timeout toggle into the link domain
    tws_sync #(.W(7)) u_lsync (
        .clk(clk_link),
        .d({addr_strap_first, addr_strap_second, alert_oe, alert_cause,
            tout_tog}),
        .q(lsync)
    );
    assign alert_act = lsync[2];

    function automatic logic [6:0] strap_addr(input logic [1:0] a,
                                              input logic [1:0] b);
        logic [6:0] base;
        base = `TWS_BASE_GND;
        if (a == `TWS_STRAP_OPEN) base = `TWS_BASE_OPEN;
        if (a == `TWS_STRAP_VCC) base = `TWS_BASE_VCC;
        return base + 7'(b == `TWS_STRAP_VCC ? 2'h2 : b);
    endfunction

    // Straps caught once after reset release, never from a port under reset
    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            strap_taken <= 1'b0;
            my_addr <= 7'h00;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            my_addr <= strap_addr(lsync[6:5], lsync[4:3]); // RQ9
        end
    end

    // Byte to send: alert answer carries address and cause bit
    function automatic logic [7:0] tx_pick(input logic ara,
                                           input logic low_half,
                                           input logic [6:0] a,
                                           input logic cause,
                                           input logic [15:0] d);
        if (ara) return {a, cause}; // RQ24
        return low_half ? d[7:0] : d[15:8]; // RQ13
    endfunction
    assign tx = tx_pick(is_ara, lsb, my_addr, lsync[1], rd_data);

    // Line edges and bus conditions on the filtered levels
    assign scl_rise = line.scl & ~scl_q;
    assign scl_fall = ~line.scl & scl_q;
    assign start_ev = scl_q & line.scl & sda_q & ~line.sda; // RQ4
    assign stop_ev = scl_q & line.scl & ~sda_q & line.sda; // RQ4
    assign tout_ev = lsync[0] ^ tout_q;

    // Link engine next state
    always_comb begin
        next_st = st;
        next_sh = sh;
        next_cnt = cnt;
        next_is_addr = is_addr;
        next_is_read = is_read;
        next_is_ara = is_ara;
        next_first_data = first_data;
        next_hs = hs;
        next_oe = oe;
        next_ack_ok = ack_ok;
        next_lsb = lsb;
        next_in_frame = in_frame;
        next_arb_lost = arb_lost;
        next_ptr = reg_ptr;
        next_wr_data = wr_data;
        next_wr_strobe = 1'b0;
        next_tog_rd = tog_rd;
        next_tog_won = tog_won;
        if (tout_ev || stop_ev) begin
            // Stop or timeout: release and await the next START
            next_st = tws_pkg::TWS_IDLE; // RQ18
            next_oe = 1'b0;
            next_in_frame = 1'b0;
            next_hs = 1'b0; // RQ17
        end else if (start_ev) begin
            // Repeated START keeps high-speed mode
            next_st = tws_pkg::TWS_RX;
            next_is_addr = 1'b1;
            next_cnt = 4'h0;
            next_oe = 1'b0;
            next_in_frame = 1'b1;
        end else begin
            unique case (st)
                tws_pkg::TWS_IDLE: begin
                end
                tws_pkg::TWS_RX: begin
                    if (scl_rise) begin
                        next_sh = {sh[6:0], line.sda}; // RQ6
                        next_cnt = cnt + 4'h1;
                    end
                    if (scl_fall && cnt == `TWS_BIT_LAST) begin
                        next_st = tws_pkg::TWS_ACK;
                        next_oe = 1'b1; // RQ3
                        if (!is_addr) begin
                            next_first_data = 1'b0;
                            if (first_data) begin
                                next_ptr = sh; // RQ10 RQ11
                            end else begin
                                next_wr_data = sh;
                                next_wr_strobe = 1'b1; // RQ14
                            end
                        end else if (sh[7:3] == `TWS_HS_CODE) begin
                            next_hs = 1'b1; // RQ16
                            next_st = tws_pkg::TWS_IDLE;
                            next_oe = 1'b0;
                        end else if (sh[7:1] == my_addr) begin
                            next_is_read = sh[0]; // RQ8
                            next_is_ara = 1'b0;
                            next_first_data = 1'b1;
                            next_lsb = 1'b0;
                            next_tog_rd = tog_rd ^ sh[0]; // RQ22
                        end else if (sh == `TWS_ARA_CMD && alert_act) begin
                            next_is_read = 1'b1; // RQ24
                            next_is_ara = 1'b1;
                        end else begin
                            next_st = tws_pkg::TWS_IDLE;
                            next_oe = 1'b0;
                        end
                    end
                end
                tws_pkg::TWS_ACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        next_is_addr = 1'b0;
                        next_arb_lost = 1'b0;
                        if (is_read) begin
                            next_st = tws_pkg::TWS_TX;
                            next_sh = tx;
                            next_oe = ~tx[7]; // RQ6
                            next_lsb = ~lsb;
                        end else begin
                            next_st = tws_pkg::TWS_RX;
                            next_oe = 1'b0;
                        end
                    end
                end
                tws_pkg::TWS_TX: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                        // Released a one but saw zero: arbitration lost
                        if (!oe && !line.sda) next_arb_lost = 1'b1; // RQ24
                    end
                    if (scl_fall) begin
                        if (cnt == `TWS_BIT_LAST) begin
                            next_st = tws_pkg::TWS_MACK;
                            next_oe = 1'b0;
                            next_tog_won = tog_won ^ (is_ara & ~arb_lost);
                        end else begin
                            next_sh = {sh[6:0], 1'b0};
                            next_oe = ~sh[6] & ~arb_lost;
                        end
                    end
                end
                tws_pkg::TWS_MACK: begin
                    if (scl_rise) next_ack_ok = ~line.sda;
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (ack_ok && !is_ara) begin
                            next_st = tws_pkg::TWS_TX;
                            next_sh = tx;
                            next_oe = ~tx[7];
                            next_lsb = ~lsb;
                        end else begin
                            next_st = tws_pkg::TWS_IDLE; // RQ15
                        end
                    end
                end
            endcase
        end
    end

    // Link engine registers
    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            st <= tws_pkg::TWS_IDLE;
            sh <= 8'h00;
            cnt <= 4'h0;
            is_addr <= 1'b0;
            is_read <= 1'b0;
            is_ara <= 1'b0;
            first_data <= 1'b0;
            hs <= 1'b0;
            oe <= 1'b0;
            ack_ok <= 1'b0;
            lsb <= 1'b0;
            in_frame <= 1'b0;
            arb_lost <= 1'b0;
            reg_ptr <= 8'h00;
            wr_data <= 8'h00;
            wr_strobe <= 1'b0;
            tog_rd <= 1'b0;
            tog_won <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            tout_q <= 1'b0;
        end else begin
            st <= next_st;
            sh <= next_sh;
            cnt <= next_cnt;
            is_addr <= next_is_addr;
            is_read <= next_is_read;
            is_ara <= next_is_ara;
            first_data <= next_first_data;
            hs <= next_hs;
            oe <= next_oe;
            ack_ok <= next_ack_ok;
            lsb <= next_lsb;
            in_frame <= next_in_frame;
            arb_lost <= next_arb_lost;
            reg_ptr <= next_ptr;
            wr_data <= next_wr_data;
            wr_strobe <= next_wr_strobe;
            tog_rd <= next_tog_rd;
            tog_won <= next_tog_won;
            scl_q <= line.scl;
            sda_q <= line.sda;
            tout_q <= lsync[0];
        end
    end

    // ---- System domain: timeout timer and alarm ----
    logic [2:0] sev_q, next_sev_q;
    logic [21:0] tcnt, next_tcnt;
    logic next_tout_tog;
    logic [2:0] vcnt, next_vcnt, need;
    logic alert_lat, next_alert_lat, next_alert_cause, next_alert_oe;
    logic rd_ev, won_ev;

    // Read-address and win events, plus a bus-low level, from the link
    tws_sync #(.W(3)) u_ssync (
        .clk(clk_sys),
        .d({tog_rd, tog_won, in_frame & ~(line.scl & line.sda)}),
        .q(ssync)
    );
    assign rd_ev = ssync[2] ^ sev_q[2];
    assign won_ev = ssync[1] ^ sev_q[1];

    // Unlisted codes fall back to one conversion
    function automatic logic [2:0] consec_need(input logic [2:0] c);
        unique case (c)
            `TWS_CONSEC_2: return 3'h2; // RQ23
            `TWS_CONSEC_3: return 3'h3;
            `TWS_CONSEC_4: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction
    assign need = consec_need({consec_count_bit_hi, consec_count_bit_mid,
                               consec_count_bit_lo});

    always_comb begin
        next_sev_q = ssync;
        next_tout_tog = tout_tog;
        next_tcnt = 22'h0;
        // Timer counts only while a line is low inside a frame
        if (timeout_en && ssync[0]) begin
            next_tcnt = tcnt + 22'h1;
            if (tcnt == 22'(TOUT_CYC - 1)) begin
                next_tcnt = 22'h0;
                next_tout_tog = ~tout_tog; // RQ18
            end
        end
        next_vcnt = vcnt;
        next_alert_lat = alert_lat;
        next_alert_cause = alert_cause;
        // Address-read clear needs a quiet last conversion and reset status flags; a win clears alone
        if ((rd_ev && vcnt == 3'h0 && !remote_open && status_clear)
            || won_ev) begin
            next_alert_lat = 1'b0; // RQ22 RQ24
        end
        if (conv_done) begin
            next_vcnt = 3'h0;
            if (conv_high || conv_low) begin
                next_vcnt = (vcnt == 3'h4) ? vcnt : vcnt + 3'h1;
            end
            // A new violation beats a clear in the same cycle
            if ((conv_high || conv_low) && next_vcnt >= need) begin
                next_alert_lat = 1'b1; // RQ19
                next_alert_cause = conv_high;
            end
        end
        next_alert_oe = ~alert_mask // RQ21
            & (next_alert_lat | remote_open); // RQ20
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sev_q <= 3'h0;
            tcnt <= 22'h0;
            tout_tog <= 1'b0;
            vcnt <= 3'h0;
            alert_lat <= 1'b0;
            alert_cause <= 1'b0;
            alert_oe <= 1'b0;
        end else begin
            sev_q <= next_sev_q;
            tcnt <= next_tcnt;
            tout_tog <= next_tout_tog;
            vcnt <= next_vcnt;
            alert_lat <= next_alert_lat;
            alert_cause <= next_alert_cause;
            alert_oe <= next_alert_oe;
        end
    end

    // ---- Checks ----
    chk_scl_released: assert property (@(posedge clk_link) // RQ1
        disable iff (rst_link) !scl_oe)
        else $error("clock line driven");
    chk_hs_code_nack: assert property (@(posedge clk_link) // RQ16
        disable iff (rst_link)
        st == tws_pkg::TWS_RX && is_addr && scl_fall && !start_ev
        && !stop_ev && !tout_ev && cnt == `TWS_BIT_LAST
        && sh[7:3] == `TWS_HS_CODE |=> hs && !oe)
        else $error("high-speed code acknowledged");
    chk_stop_ends_hs: assert property (@(posedge clk_link) // RQ17
        disable iff (rst_link) stop_ev |=> !hs && st == tws_pkg::TWS_IDLE)
        else $error("high-speed kept after stop");
    chk_ptr_load: assert property (@(posedge clk_link) // RQ10
        disable iff (rst_link)
        st == tws_pkg::TWS_RX && !is_addr && first_data && scl_fall
        && cnt == `TWS_BIT_LAST && !start_ev && !stop_ev && !tout_ev
        |=> reg_ptr == $past(sh) && st == tws_pkg::TWS_ACK)
        else $error("pointer not loaded");
    chk_ack_drive: assert property (@(posedge clk_link) // RQ3
        disable iff (rst_link) st == tws_pkg::TWS_ACK |-> oe)
        else $error("acknowledge not driven");
    chk_tout_release: assert property (@(posedge clk_link) // RQ18
        disable iff (rst_link) tout_ev |=> !oe && !in_frame)
        else $error("timeout did not release bus");
    chk_mask_quiet: assert property (@(posedge clk_sys) // RQ21
        disable iff (rst) $past(alert_mask) && !$past(rst) |-> !alert_oe)
        else $error("masked alarm driven");
    chk_open_alarm: assert property (@(posedge clk_sys) // RQ20
        disable iff (rst) remote_open && !alert_mask |=> alert_oe)
        else $error("open sensor not flagged");
    chk_one_consec: assert property (@(posedge clk_sys) // RQ19
        disable iff (rst) conv_done && conv_high && need == 3'h1
        |=> alert_lat && alert_cause)
        else $error("single violation missed");
    cov_hs_entry: cover property (@(posedge clk_link)
        disable iff (rst_link) !hs ##1 hs);
    cov_read_ack: cover property (@(posedge clk_link)
        disable iff (rst_link) st == tws_pkg::TWS_ACK && is_read);
    cov_ara_win: cover property (@(posedge clk_sys)
        disable iff (rst) won_ev);
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench: bus master traffic plus alarm stimulus
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, ack;
    logic conv_done = 1'b0, conv_high = 1'b0, conv_low = 1'b0;
    logic remote_open = 1'b0, status_clear = 1'b0, alert_mask = 1'b0;
    logic timeout_en = 1'b0, m_scl, m_sda, scl_oe, sda_oe, wr_strobe;
    logic hs_mode, alert_oe;
    logic [2:0] consec = 3'h0, od;
    logic [7:0] reg_ptr, wr_data, rx, wr_seen = 8'h00;
    int tests_run = 0, fail_count = 0, cyc = 0;
    wire logic scl_i = ~(scl_oe | m_scl);
    wire logic sda_i = ~(sda_oe | m_sda);
    // Two unrelated clocks
    always #10 clk_sys = ~clk_sys;
    always #6 clk_link = ~clk_link;
    tws_top #(.TOUT_CYC(200)) tws_top_inst (.clk_sys, .rst, .clk_link,
        .scl_i, .scl_o(od[2]), .scl_oe, .sda_i, .sda_o(od[1]), .sda_oe,
        .addr_strap_first(2'h1), .addr_strap_second(2'h2), .reg_ptr,
        .rd_data(16'hc35a), .wr_data, .wr_strobe, .hs_mode, .conv_done,
        .conv_high, .conv_low, .remote_open, .status_clear, .alert_mask,
        .consec_count_bit_hi(consec[2]), .consec_count_bit_mid(consec[1]),
        .consec_count_bit_lo(consec[0]), .timeout_en, .alert_oe,
        .alert_o(od[0]));
    tws_mst tws_mst_inst (.clk(clk_sys), .sda(sda_i), .scl_low(m_scl),
        .sda_low(m_sda));
    // Strobe is one link cycle wide, so catch it in its own domain
    always @(posedge clk_link) if (wr_strobe) wr_seen <= wr_data;
    // Watchdog; the run needs roughly 6500 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic x(input logic [7:0] t, input logic k);
        tws_mst_inst.xfer(t, k, rx, ack);
    endtask
    // One conversion result, then time for the alarm to follow
    task automatic conv(input logic h, input logic l);
        conv_high = h;
        conv_low = l;
        conv_done = 1'b1;
        @(negedge clk_sys);
        conv_done = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic rd_addr();
        tws_mst_inst.start();
        x(8'h57, 1'b1);
        x(8'hff, 1'b1);
        tws_mst_inst.stop();
    endtask
    task automatic t_write();
        tws_mst_inst.start();
        x(8'h56, 1'b1);
        `CHK("addr_ack", 1'b1, ack)
        repeat (250) @(negedge clk_sys);
        x(8'ha5, 1'b1);
        `CHK("reg_ptr", 8'ha5, reg_ptr)
        x(8'h3c, 1'b1);
        x(8'hc3, 1'b1);
        `CHK("wr_data", 8'hc3, wr_seen)
        tws_mst_inst.stop();
    endtask
    task automatic t_read();
        for (int i = 0; i < 2; i++) begin
            tws_mst_inst.start();
            x(8'h57, 1'b1);
            x(8'hff, 1'b0);
            `CHK("rd_hi", 8'hc3, rx)
            x(8'hff, 1'b1);
            `CHK("rd_lo", 8'h5a, rx)
            tws_mst_inst.stop();
        end
        `CHK("ptr_kept", 8'ha5, reg_ptr)
    endtask
    task automatic t_hs();
        tws_mst_inst.start();
        x(8'h09, 1'b1);
        `CHK("hs_nack", 1'b0, ack)
        `CHK("hs_on", 1'b1, hs_mode)
        tws_mst_inst.start();
        x(8'h30, 1'b1);
        `CHK("other_addr", 1'b0, ack)
        `CHK("hs_kept", 1'b1, hs_mode)
        tws_mst_inst.stop();
        `CHK("hs_off", 1'b0, hs_mode)
    endtask
    // Clock held low past the limit; a later byte must be ignored
    task automatic t_tout();
        timeout_en = 1'b1;
        tws_mst_inst.start();
        x(8'h56, 1'b1);
        repeat (250) @(negedge clk_sys);
        x(8'h11, 1'b1);
        `CHK("tout_nack", 1'b0, ack)
        `CHK("tout_ptr", 8'ha5, reg_ptr)
        tws_mst_inst.stop();
    endtask
    task automatic t_alarm();
        for (int k = 0; k < 4; k++) begin
            consec = 3'((1 << k) - 1);
            repeat (k) conv(1'b1, 1'b0);
            `CHK("alert_early", 1'b0, alert_oe)
            conv(1'b0, 1'b1);
            `CHK("alert_set", 1'b1, alert_oe)
            conv(1'b0, 1'b0);
            status_clear = 1'b1;
            rd_addr();
            `CHK("alert_clr", 1'b0, alert_oe)
            status_clear = 1'b0;
        end
    endtask
    task automatic t_mask();
        consec = 3'h0;
        remote_open = 1'b1;
        conv(1'b0, 1'b0);
        `CHK("open_alert", 1'b1, alert_oe)
        alert_mask = 1'b1;
        conv(1'b1, 1'b0);
        `CHK("masked", 1'b0, alert_oe)
        alert_mask = 1'b0;
        remote_open = 1'b0;
        conv(1'b0, 1'b0);
        rd_addr();
        `CHK("held", 1'b1, alert_oe)
        status_clear = 1'b1;
        rd_addr();
        status_clear = 1'b0;
    endtask
    task automatic t_ara();
        conv(1'b1, 1'b0);
        tws_mst_inst.start();
        x(8'h19, 1'b1);
        `CHK("ara_ack", 1'b1, ack)
        x(8'hff, 1'b1);
        `CHK("ara_addr", 8'h57, rx)
        tws_mst_inst.stop();
        `CHK("ara_clr", 1'b0, alert_oe)
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        repeat (30) @(negedge clk_sys);
        `CHK("alert_idle", 1'b0, alert_oe)
        t_write();
        t_read();
        t_hs();
        t_tout();
        t_alarm();
        t_mask();
        t_ara();
        `CHK("scl_oe", 1'b0, scl_oe)
        `CHK("od_low", 3'h0, od)
        test_done();
    end
endmodule
`default_nettype wire

/* File: verification/tws_mst.sv */
// Bus master model pulling the open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none
module tws_mst (
    input wire logic clk,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // Both lines released at start: the pull-ups keep the bus idle
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Ten system cycles per half bit, well above the engine's minimum
    task automatic half();
        repeat (10) @(negedge clk);
    endtask
    // Data falls while clock high; also serves as repeated start
    task automatic start();
        sda_low = 1'b0;
        half();
        scl_low = 1'b0;
        half();
        sda_low = 1'b1;
        half();
        scl_low = 1'b1;
        half();
    endtask
    // Data rises while clock high, then the bus rests
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl_low = 1'b0;
        half();
        sda_low = 1'b0;
        half();
    endtask
    // Data moves only while clock is low; sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        half();
        scl_low = 1'b0;
        half();
        r = sda;
        scl_low = 1'b1;
    endtask
    // Eight bits MSB first then the acknowledge slot; a one releases
    task automatic xfer(input logic [7:0] t, input logic mack,
        output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(t[i], r[i]);
        bit_io(mack, a);
        ack = ~a;
    endtask
endmodule
`default_nettype wire
